// >>> hdl/cgsi_regs.svh
// Notes on behaviour
// - enable state flag mirrors real state, no irq
// - bus off bit; only entering it flags
// - error passive bit never raises an irq
// - summary bit 7 ORs all enabled sources but timer wrap
// - bus off flag set leaving error passive
// - timer wrap flag set on FFFF to 0
// - timer handler entry also clears wrap flag
// - buffer done flag clears only after reconfiguration
// - unclaimed stuff error sets general flag
// - unclaimed crc mismatch sets general flag
// - unclaimed form violation sets general flag
// - missing acknowledge sets general flag
// - writing one clears a general flag
// - global enable bit 7, timer enable bit 0
// - six category enables, one means enabled
// - object in use set when configured enabled
// - done flag clears in use bit, except rx done on an auto reply object
// - disable, abort or standby clears in use
// - fifteen per object irq enables, two bytes
// - fifteen read only per object pending bits
// - pending when object flag meets category enable
// - bit clock period is prescaler plus one
`ifndef CGSI_REGS_SVH
`define CGSI_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define CGSI_OFS_STATUS   8'h00
`define CGSI_OFS_FLAGS    8'h04
`define CGSI_OFS_ENABLES  8'h08
`define CGSI_OFS_USE_LO   8'h0C
`define CGSI_OFS_USE_HI   8'h10
`define CGSI_OFS_OIE_LO   8'h14
`define CGSI_OFS_OIE_HI   8'h18
`define CGSI_OFS_PEND_LO  8'h1C
`define CGSI_OFS_PEND_HI  8'h20
`define CGSI_OFS_TIMING   8'h24
// ****************************************
// field positions
// ****************************************
`define CGSI_POS_ENA_STATE 2
`define CGSI_POS_BUS_OFF   1
`define CGSI_POS_ERR_PASS  0
`define CGSI_POS_SUMMARY   7
`define CGSI_POS_BUS_OFF_STATE_FLAG 6
`define CGSI_POS_WRAP      5
`define CGSI_POS_BUF_DONE  4
`define CGSI_POS_STUFF     3
`define CGSI_POS_CRC       2
`define CGSI_POS_FORM      1
`define CGSI_POS_ACK       0
`define CGSI_POS_GLOBAL_EN 7
`define CGSI_POS_BUS_OFF_STATE_EN   6
`define CGSI_POS_RX_EN     5
`define CGSI_POS_TX_EN     4
`define CGSI_POS_OERR_EN   3
`define CGSI_POS_BUF_EN    2
`define CGSI_POS_GERR_EN   1
`define CGSI_POS_WRAP_EN   0
`define CGSI_BRP_LSB       1
`define CGSI_BRP_MSB       6
// ****************************************
// reset values and counts
// ****************************************
`define CGSI_RST_BYTE      8'h00
`define CGSI_RST_OBJ       15'h0000
`define CGSI_NUM_OBJ       15
`define CGSI_BRP_W         6
`define CGSI_TIMER_MAX     16'hFFFF
`endif

// >>> hdl/cgsi_pkg.sv
package cgsi_pkg;
    typedef logic [7:0]  cgsi_byte_t;
    typedef logic [14:0] cgsi_objvec_t;
    typedef logic [31:0] cgsi_word_t;
endpackage : cgsi_pkg

// >>> hdl/cgsi_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgsi_regs.svh"
module cgsi_prescaler import cgsi_pkg::*; #(
    parameter int BRPW = `CGSI_BRP_W
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            run,
    input  wire logic [BRPW-1:0] baud_prescaler,
    output var  logic            tick_ff
);
    logic [BRPW-1:0] cnt_ff;
    wire             last = (cnt_ff >= baud_prescaler);
    wire [BRPW-1:0]  nxt_cnt = (!run || last) ? '0 : cnt_ff + 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= run && last;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick_ff && run && $stable(baud_prescaler) && baud_prescaler == '0 |=> tick_ff || !$past(run))
        else $error("prescaler tick missing at divide by one");
    tick_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(tick_ff) && baud_prescaler != '0 && $stable(baud_prescaler) |=> !tick_ff)
        else $error("prescaler tick too soon");
endmodule : cgsi_prescaler
`default_nettype wire

// >>> hdl/cgsi_objects.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgsi_regs.svh"
module cgsi_objects import cgsi_pkg::*; #(
    parameter int NOBJ = `CGSI_NUM_OBJ
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [NOBJ-1:0] cfg_en,
    input  wire logic [NOBJ-1:0] cfg_dis,
    input  wire logic [NOBJ-1:0] tx_done,
    input  wire logic [NOBJ-1:0] rx_done,
    input  wire logic [NOBJ-1:0] err,
    input  wire logic [NOBJ-1:0] auto_reply,
    input  wire logic            abort,
    input  wire logic            standby_enter,
    input  wire logic            rx_en,
    input  wire logic            tx_en,
    input  wire logic            err_en,
    output var  logic [NOBJ-1:0] in_use_ff,
    output var  logic [NOBJ-1:0] pending_ff
);
    genvar i;
    generate
        for (i = 0; i < NOBJ; i++) begin : g_obj
            // a hard clear beats a fresh enable so abort really empties
            wire hard_clr = cfg_dis[i] | abort | standby_enter;
            wire done_clr = tx_done[i] | (rx_done[i] & ~auto_reply[i]);
            wire nxt_use  = hard_clr ? 1'b0 : (cfg_en[i] ? 1'b1 : (done_clr ? 1'b0 : in_use_ff[i]));
            wire nxt_pend = (rx_done[i] & rx_en) | (tx_done[i] & tx_en) | (err[i] & err_en);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    in_use_ff[i]  <= 1'b0;
                    pending_ff[i] <= 1'b0;
                end else begin
                    in_use_ff[i]  <= nxt_use;
                    pending_ff[i] <= nxt_pend;
                end
            end
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    use_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_en[0] && !cfg_dis[0] && !abort && !standby_enter |=> in_use_ff[0])
        else $error("object in use not set");
    use_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        tx_done[14] && !cfg_en[14] |=> !in_use_ff[14])
        else $error("object in use not cleared by done");
    use_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
        abort |=> in_use_ff == '0)
        else $error("abort left an object in use");
    pend_cat_a: assert property (@(posedge clk) disable iff (!rst_n)
        rx_done[0] && rx_en |=> pending_ff[0] ##1 (pending_ff[0] || !$past(rx_done[0]) || !$past(rx_en)))
        else $error("pending not raised by enabled category");
endmodule : cgsi_objects
`default_nettype wire

// >>> hdl/cgsi_top.sv
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cgsi_regs.svh"
module cgsi_top import cgsi_pkg::*; (
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,

    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,

    input  wire logic        ENABLE_STATE,
    input  wire logic        BUS_OFF,
    input  wire logic        ERR_PASSIVE,
    input  wire logic [15:0] TIMER_CNT,
    input  wire logic        TIMER_ISR_ENTER,

    input  wire logic        BUF_RX_DONE,
    input  wire logic        BUF_CFG_DONE,
    input  wire logic        GEN_STUFF_ERR,
    input  wire logic        GEN_CRC_ERR,
    input  wire logic        GEN_FORM_ERR,
    input  wire logic        GEN_ACK_ERR,

    input  wire logic [14:0] OBJ_CFG_EN,
    input  wire logic [14:0] OBJ_CFG_DIS,
    input  wire logic [14:0] OBJ_TX_DONE,
    input  wire logic [14:0] OBJ_RX_DONE,
    input  wire logic [14:0] OBJ_ERR,
    input  wire logic [14:0] OBJ_AUTO_REPLY,
    input  wire logic        ABORT_REQ,

    output var  logic        IRQ,
    output var  logic        TIMER_IRQ,
    output var  logic        BAUD_TICK
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_ff;
    logic rst_n;

    // release reaches the logic on an edge, never mid-cycle
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    // ****************************************
    // state
    // ****************************************
    logic         ena_state_ff;
    logic         bus_off_ff;
    logic         err_pass_ff;
    logic [15:0]  timer_prev_ff;

    logic [6:0]   flags_ff;
    cgsi_byte_t   enables_ff;
    cgsi_objvec_t obj_ie_ff;
    logic [5:0]   brp_ff;

    cgsi_objvec_t in_use;
    cgsi_objvec_t pending;

    logic         pready_ff;
    logic         pslverr_ff;
    cgsi_word_t   prdata_ff;

    logic         irq_ff;
    logic         timer_irq_ff;
    logic         baud_tick;

    // ****************************************
    // bus decode
    // ****************************************
    wire setup    = PSEL & ~PENABLE;
    wire wr_fire  = PSEL & PENABLE & PWRITE & pready_ff;

    wire hit_stat = (PADDR == `CGSI_OFS_STATUS);
    wire hit_flg  = (PADDR == `CGSI_OFS_FLAGS);
    wire hit_ena  = (PADDR == `CGSI_OFS_ENABLES);
    wire hit_ulo  = (PADDR == `CGSI_OFS_USE_LO);
    wire hit_uhi  = (PADDR == `CGSI_OFS_USE_HI);
    wire hit_ilo  = (PADDR == `CGSI_OFS_OIE_LO);
    wire hit_ihi  = (PADDR == `CGSI_OFS_OIE_HI);
    wire hit_plo  = (PADDR == `CGSI_OFS_PEND_LO);
    wire hit_phi  = (PADDR == `CGSI_OFS_PEND_HI);
    wire hit_tim  = (PADDR == `CGSI_OFS_TIMING);

    wire hit_any  = hit_stat | hit_flg | hit_ena | hit_ulo | hit_uhi
                  | hit_ilo | hit_ihi | hit_plo | hit_phi | hit_tim;

    wire wr_flg   = wr_fire & hit_flg;
    wire wr_ena   = wr_fire & hit_ena;
    wire wr_ilo   = wr_fire & hit_ilo;
    wire wr_ihi   = wr_fire & hit_ihi;
    wire wr_tim   = wr_fire & hit_tim;

    // ****************************************
    // general flags
    // ****************************************
    // entry into bus off only counts when coming from error passive
    wire bus_off_state_enter = BUS_OFF & ~bus_off_ff & err_pass_ff;
    wire wrap_hit   = (timer_prev_ff == `CGSI_TIMER_MAX) && (TIMER_CNT == 16'h0000);

    logic [6:0] set_vec;
    logic [6:0] clr_vec;
    assign set_vec[`CGSI_POS_BUS_OFF_STATE_FLAG] = bus_off_state_enter;
    assign set_vec[`CGSI_POS_WRAP]      = wrap_hit;
    assign set_vec[`CGSI_POS_BUF_DONE]  = BUF_RX_DONE;
    assign set_vec[`CGSI_POS_STUFF]     = GEN_STUFF_ERR;
    assign set_vec[`CGSI_POS_CRC]       = GEN_CRC_ERR;
    assign set_vec[`CGSI_POS_FORM]      = GEN_FORM_ERR;
    assign set_vec[`CGSI_POS_ACK]       = GEN_ACK_ERR;

    // a zero bit leaves its flag alone
    wire [6:0] w1c  = wr_flg ? PWDATA[6:0] : 7'h00;
    assign clr_vec[`CGSI_POS_BUS_OFF_STATE_FLAG] = w1c[`CGSI_POS_BUS_OFF_STATE_FLAG];
    assign clr_vec[`CGSI_POS_WRAP]      = w1c[`CGSI_POS_WRAP] | TIMER_ISR_ENTER;
    assign clr_vec[`CGSI_POS_BUF_DONE]  = w1c[`CGSI_POS_BUF_DONE] & BUF_CFG_DONE;
    assign clr_vec[3:0]                 = w1c[3:0];

    // a set arriving with its clear survives
    wire [6:0] nxt_flags = (flags_ff & ~clr_vec) | set_vec;

    // ****************************************
    // enables and summary
    // ****************************************
    wire glob_en  = enables_ff[`CGSI_POS_GLOBAL_EN];
    wire wrap_en  = enables_ff[`CGSI_POS_WRAP_EN];
    wire bus_off_state_en  = enables_ff[`CGSI_POS_BUS_OFF_STATE_EN];
    wire rx_en    = enables_ff[`CGSI_POS_RX_EN];
    wire tx_en    = enables_ff[`CGSI_POS_TX_EN];
    wire oerr_en  = enables_ff[`CGSI_POS_OERR_EN];
    wire buf_en   = enables_ff[`CGSI_POS_BUF_EN];
    wire gerr_en  = enables_ff[`CGSI_POS_GERR_EN];

    wire gen_err  = |flags_ff[`CGSI_POS_STUFF:`CGSI_POS_ACK];
    // pending bits are already gated by their category enables
    wire obj_irq  = |(pending & obj_ie_ff);
    // the wrap flag is left out so its own handler owns it
    wire summary  = (flags_ff[`CGSI_POS_BUS_OFF_STATE_FLAG] & bus_off_state_en)
                  | (flags_ff[`CGSI_POS_BUF_DONE] & buf_en)
                  | (gen_err & gerr_en) | obj_irq;
    wire nxt_irq  = summary & glob_en;
    wire nxt_tirq = flags_ff[`CGSI_POS_WRAP] & wrap_en;

    // standby entry is seen as the enable state dropping
    wire stby_in  = ena_state_ff & ~ENABLE_STATE;

    // ****************************************
    // read data
    // ****************************************
    wire [7:0] rd_stat = {5'h00, ena_state_ff, bus_off_ff, err_pass_ff};
    wire [7:0] rd_flg  = {summary, flags_ff};
    wire [7:0] rd_tim  = {1'b0, brp_ff, 1'b0};

    wire [7:0] rd_byte = hit_stat ? rd_stat :
                         hit_flg  ? rd_flg :
                         hit_ena  ? enables_ff :
                         hit_ulo  ? in_use[7:0] :
                         hit_uhi  ? {1'b0, in_use[14:8]} :
                         hit_ilo  ? obj_ie_ff[7:0] :
                         hit_ihi  ? {1'b0, obj_ie_ff[14:8]} :
                         hit_plo  ? pending[7:0] :
                         hit_phi  ? {1'b0, pending[14:8]} :
                         hit_tim  ? rd_tim : `CGSI_RST_BYTE;

    // captured at setup, steady through the access
    wire [31:0] nxt_prdata = (setup && !PWRITE) ? {24'h000000, rd_byte} : prdata_ff;

    // ****************************************
    // bus slave
    // ****************************************
    // zero wait states: ready rises for the first access cycle only
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~hit_any;
            prdata_ff  <= nxt_prdata;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    // reserved bits are not stored and read back zero
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            enables_ff <= `CGSI_RST_BYTE;
            obj_ie_ff  <= `CGSI_RST_OBJ;
            brp_ff     <= 6'h00;
        end else begin
            if (wr_ena) enables_ff <= PWDATA[7:0];
            if (wr_ilo) obj_ie_ff[7:0] <= PWDATA[7:0];
            if (wr_ihi) obj_ie_ff[14:8] <= PWDATA[6:0];
            if (wr_tim) brp_ff <= PWDATA[`CGSI_BRP_MSB:`CGSI_BRP_LSB];
        end
    end

    // ****************************************
    // status capture and flags
    // ****************************************
    // last value kept so a state change is seen as an edge
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ena_state_ff  <= 1'b0;
            bus_off_ff    <= 1'b0;
            err_pass_ff   <= 1'b0;
            timer_prev_ff <= 16'h0000;
            flags_ff      <= 7'h00;
        end else begin
            ena_state_ff  <= ENABLE_STATE;
            bus_off_ff    <= BUS_OFF;
            err_pass_ff   <= ERR_PASSIVE;
            timer_prev_ff <= TIMER_CNT;
            flags_ff      <= nxt_flags;
        end
    end

    // ****************************************
    // interrupt outputs
    // ****************************************
    // registered so the request pins never glitch
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff       <= 1'b0;
            timer_irq_ff <= 1'b0;
        end else begin
            irq_ff       <= nxt_irq;
            timer_irq_ff <= nxt_tirq;
        end
    end

    assign PRDATA    = prdata_ff;
    assign PREADY    = pready_ff;
    assign PSLVERR   = pslverr_ff;
    assign IRQ       = irq_ff;
    assign TIMER_IRQ = timer_irq_ff;
    assign BAUD_TICK = baud_tick;

    // ****************************************
    // message objects
    // ****************************************
    cgsi_objects #(
        .NOBJ (`CGSI_NUM_OBJ)
    ) u_objects (
        .clk           (MCLK),
        .rst_n         (rst_n),
        .cfg_en        (OBJ_CFG_EN),
        .cfg_dis       (OBJ_CFG_DIS),
        .tx_done       (OBJ_TX_DONE),
        .rx_done       (OBJ_RX_DONE),
        .err           (OBJ_ERR),
        .auto_reply    (OBJ_AUTO_REPLY),
        .abort         (ABORT_REQ),
        .standby_enter (stby_in),
        .rx_en         (rx_en),
        .tx_en         (tx_en),
        .err_en        (oerr_en),
        .in_use_ff     (in_use),
        .pending_ff    (pending)
    );

    // ****************************************
    // bit clock prescaler
    // ****************************************
    // only runs while the channel is really enabled
    cgsi_prescaler #(
        .BRPW (`CGSI_BRP_W)
    ) u_prescaler (
        .clk     (MCLK),
        .rst_n   (rst_n),
        .run     (ena_state_ff),
        .baud_prescaler     (brp_ff),
        .tick_ff (baud_tick)
    );

    // ****************************************
    // checks
    // ****************************************
    bus_off_state_entry_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        $rose(flags_ff[`CGSI_POS_BUS_OFF_STATE_FLAG]) |-> $past(BUS_OFF) && !$past(bus_off_ff) && $past(err_pass_ff))
        else $error("bus off flag set without entry from error passive");

    bus_off_state_hold_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        BUS_OFF && bus_off_ff |=> !$rose(flags_ff[`CGSI_POS_BUS_OFF_STATE_FLAG]))
        else $error("bus off flag raised while staying off");

    wrap_set_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        TIMER_CNT == 16'h0000 && timer_prev_ff == `CGSI_TIMER_MAX |=> flags_ff[`CGSI_POS_WRAP])
        else $error("timer wrap flag not set");

    wrap_isr_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        TIMER_ISR_ENTER && !wrap_hit |=> !flags_ff[`CGSI_POS_WRAP])
        else $error("handler entry did not clear wrap flag");

    buf_hold_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        flags_ff[`CGSI_POS_BUF_DONE] && wr_flg && !BUF_CFG_DONE |=> flags_ff[`CGSI_POS_BUF_DONE])
        else $error("buffer flag cleared before reconfiguration");

    crc_clear_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        wr_flg && PWDATA[`CGSI_POS_CRC] && !GEN_CRC_ERR |=> !flags_ff[`CGSI_POS_CRC])
        else $error("write one did not clear crc flag");

    set_wins_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        GEN_ACK_ERR |=> flags_ff[`CGSI_POS_ACK])
        else $error("ack error flag lost");

    irq_cause_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        IRQ |-> $past(glob_en) && $past(summary))
        else $error("interrupt without enabled summary");

    irq_gate_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        !glob_en |=> !IRQ)
        else $error("interrupt while globally disabled");

    timer_irq_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        flags_ff[`CGSI_POS_WRAP] && wrap_en && !glob_en ##1 flags_ff[`CGSI_POS_WRAP] |-> TIMER_IRQ)
        else $error("timer request not independent of global enable");

    status_ro_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        $rose(ERR_PASSIVE) && !BUS_OFF |=> !$rose(flags_ff[`CGSI_POS_BUS_OFF_STATE_FLAG]))
        else $error("error passive raised an interrupt flag");

    apb_ready_a: assert property (@(posedge MCLK) disable iff (!rst_n)
        setup |=> PREADY ##1 !PREADY)
        else $error("bus answer not one cycle after setup");
endmodule : cgsi_top
`default_nettype wire

// >>> bench/cgsi_engine.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// protocol engine stand-in
// ****
module cgsi_engine (
    input  wire logic        clk,
    input  wire logic        run,
    output var  logic        err_pass,
    output var  logic        bus_off,
    output var  logic [15:0] timer,
    output var  logic [3:0]  gen_err
);
    initial begin
        err_pass = 1'b0;
        bus_off  = 1'b0;
        timer    = 16'hFFF0;
        gen_err  = 4'h0;
    end
    // starts just below the top so a wrap comes soon
    always @(posedge clk) begin
        if (run)
            timer <= timer + 16'h0001;
    end
    // confinement state moves one step per call
    task automatic conf(input logic p, input logic b);
        @(posedge clk);
        err_pass <= p;
        bus_off  <= b;
    endtask : conf
    // only frames that no object claimed are reported here
    task automatic frame_err(input int k);
        @(posedge clk);
        gen_err <= 4'h1 << k;
        @(posedge clk);
        gen_err <= 4'h0;
    endtask : frame_err
endmodule : cgsi_engine
`default_nettype wire

// >>> bench/cgsi_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgsi_regs.svh"
module cgsi_top_test import cgsi_pkg::*; ;
    localparam logic [7:0] flg = `CGSI_OFS_FLAGS;
    logic        MCLK, RSTN, PSEL, PENABLE, PWRITE, PSLVERR, PREADY;
    logic [7:0]  PADDR;
    cgsi_word_t  PWDATA, PRDATA, rd;
    logic        ENABLE_STATE, BUS_OFF, ERR_PASSIVE, TIMER_ISR_ENTER, ABORT_REQ;
    logic        BUF_RX_DONE, BUF_CFG_DONE, IRQ, TIMER_IRQ, BAUD_TICK, run, slv;
    logic [15:0] TIMER_CNT;
    logic [3:0]  gen_err;
    logic [14:0] OBJ_CFG_EN, OBJ_CFG_DIS, OBJ_TX_DONE, OBJ_RX_DONE, OBJ_ERR, OBJ_AUTO_REPLY;
    int          n_mismatch, total_checks;
    cgsi_top i_dut (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .ENABLE_STATE, .BUS_OFF, .ERR_PASSIVE, .TIMER_CNT, .TIMER_ISR_ENTER,
        .BUF_RX_DONE, .BUF_CFG_DONE, .GEN_STUFF_ERR(gen_err[3]), .GEN_CRC_ERR(gen_err[2]),
        .GEN_FORM_ERR(gen_err[1]), .GEN_ACK_ERR(gen_err[0]), .OBJ_CFG_EN, .OBJ_CFG_DIS,
        .OBJ_TX_DONE, .OBJ_RX_DONE, .OBJ_ERR, .OBJ_AUTO_REPLY, .ABORT_REQ, .IRQ, .TIMER_IRQ,
        .BAUD_TICK);
    cgsi_engine i_eng (.clk(MCLK), .run(run), .err_pass(ERR_PASSIVE), .bus_off(BUS_OFF),
        .timer(TIMER_CNT), .gen_err(gen_err));
    // ****
    // bus and compare helpers
    // ****
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    task automatic chk(input string nm, input cgsi_word_t e, input cgsi_word_t s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    // starts on a fresh edge so a release never meets a new setup in one step
    task automatic apb(input logic w, input logic [7:0] a, input cgsi_word_t d);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) n_mismatch++;
        rd  = PRDATA;
        slv = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input cgsi_word_t d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rc(input string nm, input logic [7:0] a, input cgsi_word_t e, input logic ee = 1'b0);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk(nm, {31'h0, ee}, {31'h0, slv});
    endtask : rc
    task automatic obj_on(input logic [14:0] v);
        OBJ_CFG_EN <= v;
        @(posedge MCLK);
        OBJ_CFG_EN <= 15'h0;
    endtask : obj_on
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        for (int a = 0; a <= 36; a += 4)
            rc("reset", a[7:0], 32'h0);
        rc("unmapped", 8'h28, 32'h0, 1'b1);
    endtask : t_reset
    task automatic t_state();
        wr(`CGSI_OFS_ENABLES, 32'hFF);
        ENABLE_STATE <= 1'b1;
        i_eng.conf(1'b1, 1'b0);
        rc("status", `CGSI_OFS_STATUS, 32'h05);
        rc("quiet", flg, 32'h0);
        chk("irq", 32'h0, {31'h0, IRQ});
        i_eng.conf(1'b0, 1'b1);
        rc("bus_off_state", flg, 32'hC0);
        chk("irq", 32'h1, {31'h0, IRQ});
        wr(flg, 32'h40);
        rc("bus_off_state_stay", flg, 32'h0);
        rc("status", `CGSI_OFS_STATUS, 32'h06);
        i_eng.conf(1'b0, 1'b0);
        i_eng.conf(1'b0, 1'b1);
        rc("bus_off_state_active", flg, 32'h0);
        i_eng.conf(1'b0, 1'b0);
    endtask : t_state
    task automatic t_wrap();
        wr(`CGSI_OFS_ENABLES, 32'h7F);
        run <= 1'b1;
        repeat (40) @(posedge MCLK);
        run <= 1'b0;
        rc("wrap", flg, 32'h20);
        chk("timer_irq", 32'h1, {31'h0, TIMER_IRQ});
        chk("irq", 32'h0, {31'h0, IRQ});
        TIMER_ISR_ENTER <= 1'b1;
        @(posedge MCLK);
        TIMER_ISR_ENTER <= 1'b0;
        rc("wrap_isr", flg, 32'h0);
        wr(`CGSI_OFS_ENABLES, 32'hFF);
    endtask : t_wrap
    task automatic t_gen();
        for (int k = 0; k < 4; k++) begin
            i_eng.frame_err(k);
            rc("gen", flg, 32'h80 | (32'h1 << k));
            chk("irq", 32'h1, {31'h0, IRQ});
            wr(flg, 32'h1 << k);
            rc("gen_clr", flg, 32'h0);
        end
    endtask : t_gen
    task automatic t_buf();
        BUF_RX_DONE <= 1'b1;
        @(posedge MCLK);
        BUF_RX_DONE <= 1'b0;
        wr(flg, 32'h10);
        rc("buf_keep", flg, 32'h90);
        BUF_CFG_DONE <= 1'b1;
        wr(flg, 32'h10);
        rc("buf_clr", flg, 32'h0);
        BUF_CFG_DONE <= 1'b0;
    endtask : t_buf
    task automatic t_obj();
        obj_on(15'h4001);
        rc("use_lo", `CGSI_OFS_USE_LO, 32'h01);
        rc("use_hi", `CGSI_OFS_USE_HI, 32'h40);
        OBJ_AUTO_REPLY <= 15'h4000;
        OBJ_RX_DONE <= 15'h4001;
        rc("rx_done", `CGSI_OFS_USE_LO, 32'h0);
        rc("pend_rx", `CGSI_OFS_PEND_LO, 32'h01);
        rc("auto_rx", `CGSI_OFS_USE_HI, 32'h40);
        OBJ_TX_DONE <= 15'h4000;
        rc("auto_tx", `CGSI_OFS_USE_HI, 32'h0);
        OBJ_RX_DONE <= 15'h0;
        OBJ_TX_DONE <= 15'h0;
        obj_on(15'h0008);
        ABORT_REQ <= 1'b1;
        @(posedge MCLK);
        ABORT_REQ <= 1'b0;
        rc("abort", `CGSI_OFS_USE_LO, 32'h0);
        obj_on(15'h0008);
        OBJ_CFG_DIS <= 15'h0008;
        @(posedge MCLK);
        OBJ_CFG_DIS <= 15'h0;
        rc("disable", `CGSI_OFS_USE_LO, 32'h0);
        obj_on(15'h0008);
        ENABLE_STATE <= 1'b0;
        rc("standby", `CGSI_OFS_USE_LO, 32'h0);
        ENABLE_STATE <= 1'b1;
    endtask : t_obj
    task automatic t_pend();
        wr(`CGSI_OFS_OIE_HI, 32'h7F);
        rc("oie_hi", `CGSI_OFS_OIE_HI, 32'h7F);
        OBJ_ERR <= 15'h0200;
        rc("pend_err", `CGSI_OFS_PEND_HI, 32'h02);
        rc("sum_obj", flg, 32'h80);
        chk("irq", 32'h1, {31'h0, IRQ});
        wr(`CGSI_OFS_OIE_HI, 32'h7D);
        rc("sum_mask", flg, 32'h0);
        wr(`CGSI_OFS_ENABLES, 32'hF7);
        rc("pend_off", `CGSI_OFS_PEND_HI, 32'h0);
        OBJ_ERR <= 15'h0;
    endtask : t_pend
    task automatic t_tick();
        int n;
        wr(`CGSI_OFS_TIMING, 32'h04);
        rc("timing", `CGSI_OFS_TIMING, 32'h04);
        n = 0;
        while (BAUD_TICK !== 1'b1 && n < 100) begin
            @(posedge MCLK);
            n++;
        end
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (BAUD_TICK !== 1'b1 && n < 100);
        chk("tick_gap", 32'd3, 32'(n));
    endtask : t_tick
    task automatic conclude();
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial begin
        RSTN = 1'b0;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, run} = '0;
        {ENABLE_STATE, TIMER_ISR_ENTER, BUF_RX_DONE, BUF_CFG_DONE, ABORT_REQ} = '0;
        {OBJ_CFG_EN, OBJ_CFG_DIS, OBJ_TX_DONE, OBJ_RX_DONE, OBJ_ERR, OBJ_AUTO_REPLY} = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (10) @(posedge MCLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge MCLK);
        t_reset();
        t_state();
        t_wrap();
        t_gen();
        t_buf();
        t_obj();
        t_pend();
        t_tick();
        conclude();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge MCLK);
        n_mismatch++;
        conclude();
    end
endmodule : cgsi_top_test
`default_nettype wire
